// [hw/bbo_pkg.sv]
// package for the byte and bit operation execute block
package bbo_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	// field positions inside the instruction word
	localparam int CLASS_HI = 13;
	localparam int CLASS_LO = 12;
	localparam int OP_HI = 11;
	localparam int OP_LO = 8;
	localparam int DEST_POS = 7;
	localparam int BITOP_HI = 11;
	localparam int BITOP_LO = 10;
	localparam int BIDX_HI = 9;
	localparam int BIDX_LO = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;
	// operation classes and codes
	localparam logic [1:0] CLASS_BYTE = 2'h0;
	localparam logic [1:0] CLASS_BIT = 2'h1;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [1:0] BOP_CLEAR = 2'h0;
	localparam logic [1:0] BOP_SET = 2'h1;
	localparam logic [1:0] BOP_TEST_CLR = 2'h2;
	// reset values and the nibble mask for digit carry
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [3:0] NIBBLE_MASK = 4'hF;
	typedef enum logic [2:0] {
		BBO_NONE = 3'b000,
		BBO_ADD = 3'b001,
		BBO_AND = 3'b010,
		BBO_BCLR = 3'b011,
		BBO_BSET = 3'b100,
		BBO_BTST = 3'b101
	} bbo_op_e;
endpackage

// [hw/bbo_decode.sv]
// instruction field decoder for the byte and bit operations
`timescale 1ns/1ps
module bbo_decode (
	input wire logic [bbo_pkg::INSN_W-1:0] insn,
	output bbo_pkg::bbo_op_e op,
	output logic destFile,
	output logic [bbo_pkg::BIT_W-1:0] bitIndex,
	output logic [bbo_pkg::ADDR_W-1:0] fileAddr
);
	import bbo_pkg::*;

	// operand fields are fixed slices, decoded for every word
	assign fileAddr = insn[ADDR_HI:ADDR_LO];
	assign bitIndex = insn[BIDX_HI:BIDX_LO];
	assign destFile = insn[DEST_POS];

	// top two bits pick the class, then the sub-opcode
	always_comb begin
		op = BBO_NONE;
		if (insn[CLASS_HI:CLASS_LO] == CLASS_BYTE) begin
			if (insn[OP_HI:OP_LO] == OP_ADD)
				op = BBO_ADD;
			else if (insn[OP_HI:OP_LO] == OP_AND)
				op = BBO_AND;
		end else if (insn[CLASS_HI:CLASS_LO] == CLASS_BIT) begin
			unique case (insn[BITOP_HI:BITOP_LO])
				BOP_CLEAR: op = BBO_BCLR;
				BOP_SET: op = BBO_BSET;
				BOP_TEST_CLR: op = BBO_BTST;
				default: op = BBO_NONE; // skip-if-set lives elsewhere
			endcase
		end
	end
endmodule

// [hw/bbo_execute.sv]
// execute stage for add, and, bit clear, bit set and bit test skip
// Contract
// - add accumulator and file register, update carry, digit carry, zero; one cycle
// - add result goes to accumulator when dest is 0, file when 1
// - and accumulator with file register, update zero flag only; one cycle
// - and result goes to accumulator when dest is 0, file when 1
// - bit clear zeroes the chosen file bit, flags untouched, one cycle
// - bit set raises the chosen file bit, flags untouched, one cycle
// - bit test skips next instruction as no-op when bit is zero
// - bit index is three bits, file address seven bits, low bits
`timescale 1ns/1ps
module bbo_execute (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic insnValid,
	input wire logic [bbo_pkg::INSN_W-1:0] insn,
	output logic [bbo_pkg::ADDR_W-1:0] fileReadAddr,
	input wire logic [bbo_pkg::DATA_W-1:0] fileReadData,
	output logic fileWrite,
	output logic [bbo_pkg::ADDR_W-1:0] fileWriteAddr,
	output logic [bbo_pkg::DATA_W-1:0] fileWriteData,
	output logic [bbo_pkg::DATA_W-1:0] acc,
	output logic carryFlag,
	output logic digit_carry_flag,
	output logic zeroFlag,
	output logic skipActive,
	output logic insnDone
);
	import bbo_pkg::*;

	bbo_op_e op;
	logic destFile;
	logic [BIT_W-1:0] bitIndex;
	logic [ADDR_W-1:0] fileAddr;
	logic [DATA_W:0] sum;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] bitMask;
	logic digitCarry;
	logic live;
	logic next_skip;

	// one-hot mask for the selected bit of a file register
	function automatic logic [DATA_W-1:0] bit_mask(
		input logic [BIT_W-1:0] idx
	);
		bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << idx;
	endfunction

	bbo_decode decoder (
		.insn(insn),
		.op(op),
		.destFile(destFile),
		.bitIndex(bitIndex),
		.fileAddr(fileAddr)
	);

	// the word fetched under a taken skip is swallowed as a no-op
	assign live = insnValid && !skipActive;
	assign fileReadAddr = fileAddr;
	assign bitMask = bit_mask(bitIndex);
	assign sum = {1'b0, acc} + {1'b0, fileReadData};
	assign digitCarry = ({1'b0, acc[3:0]} + {1'b0, fileReadData[3:0]})
		> {1'b0, NIBBLE_MASK};

	// result value for whichever operation is decoded
	always_comb begin
		result = fileReadData;
		unique case (op)
			BBO_ADD: result = sum[DATA_W-1:0];
			BBO_AND: result = acc & fileReadData;
			BBO_BCLR: result = fileReadData & ~bitMask;
			BBO_BSET: result = fileReadData | bitMask;
			default: result = fileReadData;
		endcase
	end

	// skip arms when the tested bit reads zero
	assign next_skip = live && (op == BBO_BTST)
		&& ((fileReadData & bitMask) == {DATA_W{1'b0}});

	// accumulator is written only by byte ops with dest 0
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			acc <= ACC_RESET;
		else if (live && (op == BBO_ADD || op == BBO_AND) && !destFile)
			acc <= result;
	end

	// file write port registered so data outputs come from flops
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fileWrite <= 1'b0;
			fileWriteAddr <= '0;
			fileWriteData <= '0;
		end else begin
			fileWrite <= live && (((op == BBO_ADD || op == BBO_AND)
				&& destFile) || op == BBO_BCLR || op == BBO_BSET);
			fileWriteAddr <= fileAddr;
			fileWriteData <= result;
		end
	end

	// flags: add touches all three, and only zero, bit ops none
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			{carryFlag, digit_carry_flag, zeroFlag} <= FLAGS_RESET;
		end else if (live && op == BBO_ADD) begin
			carryFlag <= sum[DATA_W];
			digit_carry_flag <= digitCarry;
			zeroFlag <= (sum[DATA_W-1:0] == {DATA_W{1'b0}});
		end else if (live && op == BBO_AND) begin
			zeroFlag <= (result == {DATA_W{1'b0}});
		end
	end

	// skip holds until the discarded word has been consumed
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			skipActive <= 1'b0;
		else if (skipActive && insnValid)
			skipActive <= 1'b0;
		else if (next_skip)
			skipActive <= 1'b1;
	end

	// completion pulse: every executed word is one cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			insnDone <= 1'b0;
		else
			insnDone <= insnValid;
	end
endmodule

// [tb/bbo_execute_assertions.sv]
// checker for the byte and bit execute block
`timescale 1ns/1ps
module bbo_execute_checker (
	input wire logic clk_sys, reset, insnValid, fileWrite, insnDone,
	input wire logic carryFlag, digit_carry_flag, zeroFlag, skipActive,
	input wire logic [13:0] insn,
	input wire logic [7:0] fileReadData, fileWriteData, acc
);
	logic ok;
	logic [13:0] pi;
	logic [7:0] pf, pa;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// word taken last edge, with its operand and old accumulator
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) ok <= 1'h0;
		else ok <= insnValid && !skipActive;
	end
	// no reset: only read while ok is high
	always_ff @(posedge clk_sys) begin
		pi <= insn;
		pf <= fileReadData;
		pa <= acc;
	end
	a_done_pulse: assert property (insnValid |=> insnDone)
		else $error("done");
	a_add_sum: assert property (ok && pi[13:8] == 6'h07 |->
		{carryFlag, (pi[7] ? fileWriteData : acc)} == {1'h0, pa} + pf &&
		digit_carry_flag == ({1'h0, pa[3:0]} + pf[3:0] > 5'h0F)) else $error("add");
	a_and_zero: assert property (ok && pi[13:8] == 6'h05 |->
		(pi[7] ? fileWriteData : acc) == (pa & pf) && $stable(carryFlag) &&
		zeroFlag == ((pa & pf) == 8'h00)) else $error("and");
	a_dest_route: assert property (ok && pi[13:10] == 4'h1 && pi[8] |->
		fileWrite == pi[7] && (!pi[7] || acc == pa)) else $error("dest");
	a_bit_write: assert property (ok && pi[13:11] == 3'h2 |->
		fileWrite && fileWriteData == (pi[10] ? pf | 8'h01 << pi[9:7] :
		pf & ~(8'h01 << pi[9:7]))) else $error("bit");
	a_bit_flags: assert property (ok && pi[13:12] == 2'h1 |->
		acc == pa && $stable({carryFlag, digit_carry_flag, zeroFlag}))
		else $error("flags");
	a_skip_arm: assert property (ok && pi[13:10] == 4'h6 |->
		skipActive == !pf[pi[9:7]]) else $error("arm");
	a_skip_drop: assert property (skipActive && insnValid |=>
		!fileWrite && !skipActive && $stable(acc)) else $error("drop");
	c_carry: cover property (carryFlag);
	c_skip: cover property (skipActive && insnValid);
	c_write: cover property (fileWrite);
endmodule
bind bbo_execute bbo_execute_checker chk (.*);

// [tb/bbo_execute_tb.sv]
// self-checking bench for the byte and bit execute block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module bbo_execute_tb;
	logic clk_sys = 1'h0, reset = 1'h1, insnValid = 1'h0;
	logic [13:0] insn = 14'h0000;
	logic [7:0] fileReadData = 8'h00, fileWriteData, acc;
	logic [6:0] fileReadAddr, fileWriteAddr;
	logic fileWrite, carryFlag, digit_carry_flag, zeroFlag, skipActive, insnDone;
	int n_errors = 0, tests_run = 0;
	bbo_execute uut (.*);
	// free-running clock
	always #5 clk_sys = ~clk_sys;
	// valid stays up so words can follow back to back
	task automatic exec(input logic [13:0] w, input logic [7:0] f);
		insn = w;
		fileReadData = f;
		insnValid = 1'h1;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic idle();
		insnValid = 1'h0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_arith();
		exec(14'h0723, 8'h17);
		`CHK({insnDone, acc}, 9'h117)
		exec(14'h07A3, 8'hE9);
		`CHK({fileWrite, fileWriteAddr, fileWriteData}, 16'hA300)
		`CHK({carryFlag, digit_carry_flag, zeroFlag, acc}, 11'h717)
		exec(14'h0510, 8'hC2);
		`CHK({fileWrite, carryFlag, digit_carry_flag, zeroFlag, acc}, 12'h602)
		exec(14'h05A8, 8'h28);
		`CHK({fileWrite, fileWriteData, zeroFlag, acc}, 18'h20102)
		idle();
	endtask
	task automatic t_bits();
		for (int b = 0; b < 8; b++) begin
			exec({4'h4, b[2:0], 7'h7F}, 8'hFF);
			`CHK(fileWriteData, 8'hFF ^ 8'h01 << b)
			exec({4'h5, b[2:0], 7'h7F}, 8'h00);
			`CHK(fileWriteData, 8'h01 << b)
		end
		`CHK({fileWrite, fileWriteAddr, carryFlag, digit_carry_flag, zeroFlag}, 11'h7FF)
		idle();
	endtask
	task automatic t_skip();
		exec(14'h1A7F, 8'hFB);
		`CHK(skipActive, 1'h0)
		exec(14'h1A7F, 8'hEF);
		`CHK(skipActive, 1'h1)
		exec(14'h0723, 8'h55);
		`CHK({skipActive, fileWrite, acc}, 10'h002)
		idle();
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		reset = 1'h0;
		t_arith();
		t_bits();
		t_skip();
		print_verdict();
	end
	// watchdog, far beyond the few dozen cycles the tests need
	initial begin
		#5000;
		n_errors++;
		print_verdict();
	end
endmodule
